// >>> core/dso_clear_filter.sv
// Synchroniser, debouncer and falling edge detector for the clear input.
// Assumes the raw level may change at any time.
`timescale 1ns/1ps
`default_nettype none
module dso_clear_filter (
    input  wire logic clock,
    input  wire logic sys_rst,
    dso_clr_if.filt   clr
);
    localparam logic [3:0] DEB_CNT = 4'(dso_pkg::DEBOUNCE_CYCLES);

    logic       sync_a;  // First stage
    logic       sync_b;  // Second stage
    logic       stable;  // Debounced level
    logic [3:0] settle;  // Cycles the new level has held

    // ----------------------------------------
    // Two stage synchroniser
    // ----------------------------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
        end
        else
        begin
            sync_a <= clr.raw_n;
            sync_b <= sync_a;
        end
    end

    // Level must hold DEB_CNT cycles before it is believed
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stable <= 1'b1;
            settle <= 4'h0;
        end
        else if (sync_b == stable)
            settle <= 4'h0;
        else if (settle == DEB_CNT - 4'h1)
        begin
            stable <= sync_b;
            settle <= 4'h0;
        end
        else
            settle <= settle + 4'h1;
    end

    // Pulse only on high to low; a held low gives nothing more
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            clr.clr_pulse <= 1'b0;
        else
            clr.clr_pulse <= stable && !sync_b && (settle == DEB_CNT - 4'h1);
    end
endmodule
`default_nettype wire

// >>> core/dso_clr_if.sv
// Carries the raw clear level in and the clear pulse out.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface dso_clr_if;
    logic raw_n;     // Selected clear terminal, low active
    logic clr_pulse; // One cycle per falling edge
    // ----------------------------------------
    // Views
    // ----------------------------------------
    modport filt (input raw_n, output clr_pulse);
    modport core (output raw_n, input clr_pulse);
endinterface
`default_nettype wire

// >>> core/dso_pkg.sv
// Constants for the drive status output block.
// Assumes one 10 MHz clock and a word-aligned register map.
package dso_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL      = 8'h00; // Code select
    localparam logic [7:0] REG_THRESH    = 8'h04; // Rotation threshold
    localparam logic [7:0] REG_IN_ALLOC  = 8'h08; // Clear input terminal
    localparam logic [7:0] REG_OUT_A     = 8'h0C; // Rotating/ready terminals
    localparam logic [7:0] REG_OUT_B     = 8'h10; // Brake terminal
    localparam logic [7:0] REG_STATUS    = 8'h14; // Live state, read only
    localparam logic [7:0] REG_IRQ_STAT  = 8'h18; // Sticky events
    localparam logic [7:0] REG_IRQ_MASK  = 8'h1C; // Event enables

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_CODE_SEL  = 0;  // 0: fault codes only
    localparam int OUTA_ROT_LSB   = 0;  // Rotating flag terminal
    localparam int OUTA_RDY_LSB   = 4;  // Ready flag terminal
    localparam int OUTB_BRK_LSB   = 0;  // Brake release terminal
    localparam int ST_FAULT       = 0;  // Fault latched
    localparam int ST_LOCKED      = 1;  // Encoder fault, power cycle only
    localparam int ST_CODE_LSB    = 4;  // Latched fault code, three bits
    localparam int ST_WARN        = 8;  // Warning active
    localparam int ST_ROT         = 9;  // Motor rotating
    localparam int ST_RDY         = 10; // Drive ready
    localparam int IRQ_FAULT_SET  = 0;  // A fault was latched
    localparam int IRQ_FAULT_CLR  = 1;  // A fault was cleared
    localparam int IRQ_WARN       = 2;  // Warning rose
    localparam int IRQ_REFUSED    = 3;  // Clear hit a locked fault
    localparam int IRQ_BITS       = 4;

    // ----------------------------------------
    // Reset values and limits
    // ----------------------------------------
    localparam logic [13:0] THRESH_RESET = 14'h0014; // 20 rpm
    localparam logic [13:0] THRESH_MIN   = 14'h0001; // 1 rpm
    localparam logic [13:0] THRESH_MAX   = 14'h2710; // 10000 rpm
    localparam logic [1:0]  IN_ALLOC_RST = 2'h0;     // Terminal 0
    localparam logic [1:0]  ROT_TERM_RST = 2'h0;     // Terminal 0
    localparam logic [1:0]  RDY_TERM_RST = 2'h1;     // Terminal 1
    localparam logic [1:0]  BRK_TERM_RST = 2'h2;     // Terminal 2
    localparam logic [1:0]  TERM_NONE    = 2'h3;     // Not allocated
    localparam int          OUT_TERMS    = 3;        // Output terminals

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS   = 100;  // 10 MHz
    localparam int DEBOUNCE_NS     = 1000; // Clear input settle time
    localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------
    // Fault state
    // ----------------------------------------
    typedef enum logic [1:0] {
        DSO_FLT_NONE   = 2'b00, // No fault
        DSO_FLT_LATCH  = 2'b01, // Clearable fault
        DSO_FLT_LOCKED = 2'b10  // Encoder fault
    } dso_flt_t;
endpackage

// >>> core/dso_top.sv
// Drive status outputs: fault latch, codes, warning, rotating and ready.
// Assumes synchronous inputs and an Avalon-MM master for the registers.
//
// Function
// - Fault output low normally, high on fault
// - Clear only on clear-input falling edge
// - Encoder faults clear only by power cycle
// - Keypad clear acts like input edge
// - Fault type on three code lines
// - Warning high normal, low ahead of overload
// - Select 0 fault codes; else faults win
// - Rotating flag low above speed threshold
// - Threshold 1 to 10000, reset 20, immediate
// - Shared output terminals combine with OR
// - Ready low when no fault, power on
// - Ready also needs servo-on and preparation
// - Absolute request holds ready until data sent
// - Clear input relocatable by terminal allocation
//
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module dso_top (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    // Fault sources
    input  wire logic        fault_event,
    input  wire logic [2:0]  fault_event_code,
    input  wire logic        fault_event_enc,
    input  wire logic        warn_active,
    input  wire logic [2:0]  warn_code,
    // Drive state
    input  wire logic [13:0] motor_speed,
    input  wire logic        main_power_on,
    input  wire logic        servo_on,
    input  wire logic        prep_done,
    input  wire logic        abs_encoder_fitted,
    input  wire logic        abs_data_request,
    input  wire logic        abs_data_sent,
    input  wire logic        brake_release_n,
    // Clear sources
    input  wire logic [3:0]  input_terminals_n,
    input  wire logic        keypad_clear,
    // Status pins
    output logic             fault_status_out,
    output logic             fault_code_bit0,
    output logic             fault_code_bit1,
    output logic             fault_code_bit2,
    output logic             warning_n,
    output logic             rotating_flag_n,
    output logic             ready_n,
    output logic [2:0]       output_terminals_n
);
    // ----------------------------------------
    // Registers and state
    // ----------------------------------------
    logic                code_select_setting;            // Code line mode
    logic [13:0]         rotation_threshold_setting;     // rpm
    logic [1:0]          input_terminal_alloc_setting;   // Clear terminal
    logic [1:0]          rot_term;                       // Rotating flag terminal
    logic [1:0]          rdy_term;                       // Ready flag terminal
    logic [1:0]          brk_term;                       // Brake terminal
    logic [3:0]          irq_status;                     // Sticky events
    logic [3:0]          irq_mask;                       // Event enables
    dso_pkg::dso_flt_t   flt_state;                      // Fault latch
    logic [2:0]          flt_code;                       // Latched fault type
    logic                warn_q;                         // Warning, last cycle
    logic [31:0]         next_readdata;                  // Read mux
    logic [3:0]          next_irq_set;                   // Events this cycle

    // ----------------------------------------
    // Combinational helpers
    // ----------------------------------------
    logic       bus_req;      // Request pending
    logic       bus_go;       // Request completes this edge
    logic       wr_go;        // Write completes
    logic       rd_go;        // Read completes
    logic [7:0] word_addr;    // Byte address, word aligned
    logic       clear_req;    // Any clear request
    logic       fault_any;    // Fault latched
    logic       rot_on;       // Speed above threshold
    logic       rdy_on;       // Ready conditions met
    logic       abs_ok;       // Absolute data condition
    logic [2:0] next_code;    // Code line pattern

    dso_clr_if clr_bus ();

    assign bus_req   = avs_read || avs_write;
    assign bus_go    = bus_req && !avs_waitrequest;
    assign wr_go     = bus_go && avs_write;
    assign rd_go     = bus_go && avs_read;
    assign word_addr = {avs_address[7:2], 2'b00};

    // ----------------------------------------
    // Clear input path
    // ----------------------------------------
    // Allocation picks the terminal; filtering follows so behaviour is the same
    assign clr_bus.raw_n = input_terminals_n[input_terminal_alloc_setting];

    dso_clear_filter u_clear_filter (
        .clock   (clock),
        .sys_rst (sys_rst),
        .clr     (clr_bus.filt)
    );

    // Keypad pulse merges with the filtered edge
    assign clear_req = clr_bus.clr_pulse || keypad_clear;

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    // One wait cycle per access; waitrequest drops for exactly one edge
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            avs_waitrequest <= 1'b1;
        else if (bus_req && avs_waitrequest)
            avs_waitrequest <= 1'b0;
        else
            avs_waitrequest <= 1'b1;
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        next_readdata = 32'h0000_0000;
        if (word_addr == dso_pkg::REG_CTRL)
            next_readdata[dso_pkg::CTRL_CODE_SEL] = code_select_setting;
        else if (word_addr == dso_pkg::REG_THRESH)
            next_readdata[13:0] = rotation_threshold_setting;
        else if (word_addr == dso_pkg::REG_IN_ALLOC)
            next_readdata[1:0] = input_terminal_alloc_setting;
        else if (word_addr == dso_pkg::REG_OUT_A)
        begin
            next_readdata[dso_pkg::OUTA_ROT_LSB +: 2] = rot_term;
            next_readdata[dso_pkg::OUTA_RDY_LSB +: 2] = rdy_term;
        end
        else if (word_addr == dso_pkg::REG_OUT_B)
            next_readdata[dso_pkg::OUTB_BRK_LSB +: 2] = brk_term;
        else if (word_addr == dso_pkg::REG_STATUS)
        begin
            next_readdata[dso_pkg::ST_FAULT]         = fault_any;
            next_readdata[dso_pkg::ST_LOCKED]        = (flt_state == dso_pkg::DSO_FLT_LOCKED);
            next_readdata[dso_pkg::ST_CODE_LSB +: 3] = flt_code;
            next_readdata[dso_pkg::ST_WARN]          = warn_active;
            next_readdata[dso_pkg::ST_ROT]           = rot_on;
            next_readdata[dso_pkg::ST_RDY]           = rdy_on;
        end
        else if (word_addr == dso_pkg::REG_IRQ_STAT)
            next_readdata[3:0] = irq_status;
        else if (word_addr == dso_pkg::REG_IRQ_MASK)
            next_readdata[3:0] = irq_mask;
    end

    // Data is captured as waitrequest drops, so it stands at the accept edge
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read && avs_waitrequest)
            avs_readdata <= next_readdata;
    end

    // ----------------------------------------
    // Writable settings
    // ----------------------------------------
    // Mode and allocation registers
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            code_select_setting          <= 1'b0;
            input_terminal_alloc_setting <= dso_pkg::IN_ALLOC_RST;
            rot_term                     <= dso_pkg::ROT_TERM_RST;
            rdy_term                     <= dso_pkg::RDY_TERM_RST;
            brk_term                     <= dso_pkg::BRK_TERM_RST;
            irq_mask                     <= 4'h0;
        end
        else if (wr_go)
        begin
            if (word_addr == dso_pkg::REG_CTRL)
                code_select_setting <= avs_writedata[dso_pkg::CTRL_CODE_SEL];
            else if (word_addr == dso_pkg::REG_IN_ALLOC)
                input_terminal_alloc_setting <= avs_writedata[1:0];
            else if (word_addr == dso_pkg::REG_OUT_A)
            begin
                rot_term <= avs_writedata[dso_pkg::OUTA_ROT_LSB +: 2];
                rdy_term <= avs_writedata[dso_pkg::OUTA_RDY_LSB +: 2];
            end
            else if (word_addr == dso_pkg::REG_OUT_B)
                brk_term <= avs_writedata[dso_pkg::OUTB_BRK_LSB +: 2];
            else if (word_addr == dso_pkg::REG_IRQ_MASK)
                irq_mask <= avs_writedata[3:0];
        end
    end

    // Threshold; out of range values are dropped, old value kept
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            rotation_threshold_setting <= dso_pkg::THRESH_RESET;
        else if (wr_go && word_addr == dso_pkg::REG_THRESH
                 && avs_writedata[31:14] == 18'h0_0000
                 && avs_writedata[13:0] >= dso_pkg::THRESH_MIN
                 && avs_writedata[13:0] <= dso_pkg::THRESH_MAX)
            rotation_threshold_setting <= avs_writedata[13:0];
    end

    // ----------------------------------------
    // Fault latch
    // ----------------------------------------
    // Only sys_rst, the power-up reset, leaves the locked state
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            flt_state <= dso_pkg::DSO_FLT_NONE;
            flt_code  <= 3'h0;
        end
        else
        begin
            case (flt_state)
                dso_pkg::DSO_FLT_NONE:
                begin
                    // Any new fault latches its type
                    if (fault_event)
                    begin
                        flt_code  <= fault_event_code;
                        flt_state <= fault_event_enc ? dso_pkg::DSO_FLT_LOCKED
                                                     : dso_pkg::DSO_FLT_LATCH;
                    end
                end
                dso_pkg::DSO_FLT_LATCH:
                begin
                    // Encoder fault escalates; a fresh fault beats a clear
                    if (fault_event && fault_event_enc)
                    begin
                        flt_code  <= fault_event_code;
                        flt_state <= dso_pkg::DSO_FLT_LOCKED;
                    end
                    else if (fault_event)
                        flt_state <= dso_pkg::DSO_FLT_LATCH;
                    else if (clear_req)
                    begin
                        flt_state <= dso_pkg::DSO_FLT_NONE;
                        flt_code  <= 3'h0;
                    end
                end
                dso_pkg::DSO_FLT_LOCKED:
                    flt_state <= dso_pkg::DSO_FLT_LOCKED;
                default:
                    flt_state <= dso_pkg::DSO_FLT_NONE;
            endcase
        end
    end

    assign fault_any = (flt_state != dso_pkg::DSO_FLT_NONE);

    // ----------------------------------------
    // Status conditions
    // ----------------------------------------
    // Equal speed counts as not rotating
    assign rot_on = (motor_speed > rotation_threshold_setting);

    // Absolute data must be out when the host asks for it
    assign abs_ok = !(abs_encoder_fitted && abs_data_request) || abs_data_sent;

    assign rdy_on = !fault_any && main_power_on
                    && servo_on && prep_done
                    && abs_ok;

    // Fault code wins; warnings show only in the second mode
    always_comb
    begin
        next_code = 3'h0;
        if (fault_any)
            next_code = flt_code;
        else if (code_select_setting && warn_active)
            next_code = warn_code;
    end

    // ----------------------------------------
    // Dedicated status pins
    // ----------------------------------------
    // All pins registered so the host sees clean levels
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fault_status_out <= 1'b0;
            fault_code_bit0  <= 1'b0;
            fault_code_bit1  <= 1'b0;
            fault_code_bit2  <= 1'b0;
            warning_n        <= 1'b1;
            rotating_flag_n  <= 1'b1;
            ready_n          <= 1'b1;
        end
        else
        begin
            fault_status_out <= fault_any;
            fault_code_bit0  <= next_code[0];
            fault_code_bit1  <= next_code[1];
            fault_code_bit2  <= next_code[2];
            warning_n        <= !warn_active;
            rotating_flag_n  <= !rot_on;
            ready_n          <= !rdy_on;
        end
    end

    // ----------------------------------------
    // Shared output terminals
    // ----------------------------------------
    // A terminal is ON (low) if any signal allocated to it is ON.
    // Sharing rotating and brake is legal but masks the brake release.
    for (genvar t = 0; t < dso_pkg::OUT_TERMS; t++)
    begin : g_term
        always_ff @(posedge clock or posedge sys_rst)
        begin
            if (sys_rst)
                output_terminals_n[t] <= 1'b1;
            else
                output_terminals_n[t] <= !((rot_on && rot_term == 2'(t))
                                           || (rdy_on && rdy_term == 2'(t))
                                           || (!brake_release_n && brk_term == 2'(t)));
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    // Events of this cycle
    always_comb
    begin
        next_irq_set = 4'h0;
        next_irq_set[dso_pkg::IRQ_FAULT_SET] = !fault_any && fault_event;
        next_irq_set[dso_pkg::IRQ_FAULT_CLR] = (flt_state == dso_pkg::DSO_FLT_LATCH)
                                               && clear_req && !fault_event;
        next_irq_set[dso_pkg::IRQ_WARN]      = warn_active && !warn_q;
        next_irq_set[dso_pkg::IRQ_REFUSED]   = (flt_state == dso_pkg::DSO_FLT_LOCKED)
                                               && clear_req;
    end

    // Warning edge memory
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            warn_q <= 1'b0;
        else
            warn_q <= warn_active;
    end

    // Read clears; an event in the same cycle survives
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            irq_status <= 4'h0;
        else if (rd_go && word_addr == dso_pkg::REG_IRQ_STAT)
            irq_status <= next_irq_set;
        else
            irq_status <= irq_status | next_irq_set;
    end

    // Level interrupt, one cycle behind the status bits
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            irq <= 1'b0;
        else
            irq <= |(irq_status & irq_mask);
    end
endmodule
`default_nettype wire

// >>> tb/dso_host_model.sv
// Host model: clear terminal pulses.
// Same clock as the drive.
`timescale 1ns/1ps
`default_nettype none
module dso_host_model (
    input  wire logic       clock,
    input  wire logic       clr_go,
    input  wire logic [1:0] clr_term,
    input  wire logic [4:0] clr_len,
    output logic [3:0]      term_n
);
    logic [4:0] left = '0; // Low cycles left
    // Cause removed before pulsing
    always_ff @(posedge clock) left <= clr_go ? clr_len : left - 5'(left != 5'h00);
    assign term_n = (left != 5'h00) ? ~(4'h1 << clr_term) : 4'hf;
endmodule
`default_nettype wire

// >>> tb/dso_top_bench.sv
// Bench for dso_top.
// Assumes host model, checker compiled.
`timescale 1ns/1ps
`default_nettype none
module dso_top_bench;
    logic clock=0, sys_rst=1, avs_read=0, avs_write=0, fault_event=0, fault_event_enc=0;
    logic warn_active=0, main_power_on=0, servo_on=0, prep_done=0, abs_encoder_fitted=0;
    logic abs_data_request=0, abs_data_sent=0, brake_release_n=1, keypad_clear=0, clr_go=0;
    logic avs_waitrequest, irq, fault_status_out, warning_n, rotating_flag_n, ready_n;
    logic fault_code_bit0, fault_code_bit1, fault_code_bit2;
    logic [1:0] clr_term=0;
    logic [2:0] fault_event_code=0, warn_code=0, output_terminals_n;
    logic [3:0] input_terminals_n;
    logic [4:0] clr_len=0;
    logic [7:0] avs_address=0;
    logic [13:0] motor_speed=0;
    logic [31:0] avs_writedata=0, avs_readdata, rv;
    int errors, num_checks, cyc;
    wire [2:0] code = {fault_code_bit2, fault_code_bit1, fault_code_bit0};
    dso_top u_dut (.*);
    dso_host_model u_host (.*, .term_n(input_terminals_n));
    initial forever #50 clock = ~clock;
    // Hang guard
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            errors++;
            test_done;
        end
    end
    task automatic test_done;
        $display("%0d checks %0d errors", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Hold until waitrequest low
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
        avs_address <= ad; avs_writedata <= d; avs_write <= w; avs_read <= !w;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) @(posedge clock);
        rv = avs_readdata;
        avs_write <= 0; avs_read <= 0;
        tick(1);
    endtask
    task automatic flt(input logic enc, input logic [2:0] c);
        fault_event <= 1; fault_event_enc <= enc; fault_event_code <= c;
        tick(1);
        fault_event <= 0;
        tick(3);
    endtask
    task automatic kp;
        keypad_clear <= 1;
        tick(1);
        keypad_clear <= 0;
        tick(3);
    endtask
    task automatic pin(input logic [1:0] t, input logic [4:0] n);
        clr_term <= t; clr_len <= n; clr_go <= 1;
        tick(1);
        clr_go <= 0;
        tick(20);
    endtask
    task automatic t_regs;
        bus(0, dso_pkg::REG_THRESH, 0);
        chk(rv, 32'(dso_pkg::THRESH_RESET));
        bus(1, dso_pkg::REG_THRESH, 0);
        bus(1, dso_pkg::REG_THRESH, 32'h0000_2711);
        bus(0, dso_pkg::REG_THRESH, 0);
        chk(rv, 32'h0000_0014);
        bus(1, dso_pkg::REG_THRESH, 32'h0000_2710);
        motor_speed <= 14'h2710;
        tick(3);
        chk(rotating_flag_n, 1);
        motor_speed <= 14'h2711;
        tick(3);
        chk(rotating_flag_n, 0);
        bus(0, 8'h20, 0);
        chk(rv, 0);
        $display("regs done");
    endtask
    task automatic t_fault;
        main_power_on <= 1; servo_on <= 1; prep_done <= 1; motor_speed <= 0;
        bus(1, dso_pkg::REG_IRQ_MASK, 3);
        flt(0, 3'h5);
        chk({irq, ready_n, fault_status_out, code}, 6'h3d);
        kp;
        chk({ready_n, fault_status_out}, 0);
        bus(0, dso_pkg::REG_IRQ_STAT, 0);
        chk(rv, 3);
        tick(2);
        chk(irq, 0);
        abs_encoder_fitted <= 1; abs_data_request <= 1;
        tick(3);
        chk(ready_n, 1);
        abs_data_sent <= 1;
        bus(1, dso_pkg::REG_OUT_A, 0);
        tick(3);
        chk({output_terminals_n, ready_n}, 4'hc);
        $display("fault done");
    endtask
    task automatic t_pin;
        bus(1, dso_pkg::REG_IN_ALLOC, 2);
        flt(0, 3'h1);
        pin(0, 15);
        chk(fault_status_out, 1);
        pin(2, 31);
        chk(fault_status_out, 0);
        flt(0, 3'h1);
        tick(15);
        chk(fault_status_out, 1);
        pin(2, 3);
        chk(fault_status_out, 1);
        pin(2, 15);
        chk(fault_status_out, 0);
        $display("pin done");
    endtask
    task automatic t_lock;
        bus(0, dso_pkg::REG_IRQ_STAT, 0);
        bus(1, dso_pkg::REG_IRQ_MASK, 8);
        flt(1, 3'h7);
        chk(irq, 0);
        kp;
        chk({irq, fault_status_out, code}, 5'h1f);
        bus(0, dso_pkg::REG_IRQ_STAT, 0);
        chk(rv, 9);
        tick(2);
        chk(irq, 0);
        sys_rst <= 1;
        tick(1);
        sys_rst <= 0;
        tick(2);
        chk(fault_status_out, 0);
        $display("lock done");
    endtask
    task automatic t_warn;
        warn_active <= 1; warn_code <= 3'h6;
        tick(3);
        chk({warning_n, code}, 0);
        bus(1, dso_pkg::REG_CTRL, 1);
        tick(2);
        chk(code, 3'h6);
        flt(0, 3'h2);
        chk(code, 3'h2);
        kp;
        chk(code, 3'h6);
        warn_active <= 0;
        tick(3);
        chk({warning_n, code}, 4'h8);
        $display("warn done");
    endtask
    initial
    begin
        tick(2);
        sys_rst <= 0;
        tick(1);
        t_regs; t_fault; t_pin; t_lock; t_warn;
        test_done;
    end
endmodule
`default_nettype wire

// >>> tb/dso_top_chk.sv
// Checks on dso_top pins.
// Bound onto dso_top; sees ports only.
`timescale 1ns/1ps
`default_nettype none
module dso_top_chk (
    input wire logic clock, sys_rst, fault_event, fault_event_enc, fault_status_out, keypad_clear,
    input wire logic fault_code_bit0, fault_code_bit1, fault_code_bit2, warn_active, warning_n,
    input wire logic main_power_on, servo_on, prep_done, ready_n,
    input wire logic abs_encoder_fitted, abs_data_request, abs_data_sent,
    input wire logic [2:0] fault_event_code,
    input wire logic [3:0] input_terminals_n
);
    logic [4:0] quiet; // Clear-free cycles
    wire  [2:0] code = {fault_code_bit2, fault_code_bit1, fault_code_bit0};
    // No clear in flight
    always_ff @(posedge clock or posedge sys_rst)
        if (sys_rst) quiet <= '0;
        else if (keypad_clear || input_terminals_n != 4'hf) quiet <= '0;
        else if (quiet != 5'h1f) quiet <= quiet + 5'h01;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    fault_set_a: assert property (fault_event |=> ##1 fault_status_out)
        else $error("no fault");
    fault_code_a: assert property (fault_event && !fault_event_enc && !fault_status_out
        |=> ##1 code == $past(fault_event_code, 2)) else $error("bad code");
    code_hold_a: assert property (fault_status_out && !fault_event && quiet > 5'h0f
        |=> $stable(code)) else $error("code moved");
    fault_hold_a: assert property (fault_status_out && quiet > 5'h0f |=> fault_status_out)
        else $error("fault lost");
    warn_level_a: assert property (1'b1 |=> warning_n == !$past(warn_active))
        else $error("bad warning");
    ready_pwr_a: assert property (!(main_power_on && servo_on && prep_done) |=> ready_n)
        else $error("ready early");
    ready_abs_a: assert property (abs_encoder_fitted && abs_data_request && !abs_data_sent
        |=> ready_n) else $error("abs ready");
    ready_flt_a: assert property (fault_status_out && $past(fault_status_out) |-> ready_n)
        else $error("fault ready");
    cover property (fault_event ##2 fault_status_out);
    cover property ($fell(fault_status_out));
    cover property ($fell(ready_n));
endmodule
bind dso_top dso_top_chk u_chk (.*);
`default_nettype wire
